/* File: src/adc_parallel_control_interface.sv */
// host interface, mode control and conversion sequencer of the 12-bit converter
`default_nettype none

module adc_parallel_control_interface #(
    parameter int unsigned RES_W = 12
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             chipSelect_n,
    input  wire logic             writeStrobe_n,
    input  wire logic             readStrobe_n,
    input  wire logic             highByteSelect,
    input  wire logic             convClk,
    input  wire logic [7:0]       dataIn,
    output logic      [7:0]       dataOut,
    output logic                  dataOe,
    output logic                  conversionDone_n,
    output logic                  compIn,
    input  wire logic             compOut,
    output logic      [7:0]       posInputSel,
    output logic      [7:0]       negInputSel,
    output logic                  sharedReturnSel,
    output logic                  bipolarRange,
    output logic      [RES_W-1:0] dacCode,
    output logic                  sampleHold,
    output logic                  poweredDown
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] csSync_q;
    logic [1:0] wrSync_q;
    logic [1:0] rdSync_q;
    logic [1:0] clkSync_q;
    logic [1:0] hbSync_q;
    logic [7:0] dSync1_q;
    logic [7:0] dSync2_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            csSync_q  <= 2'h3;
            wrSync_q  <= 2'h3;
            rdSync_q  <= 2'h3;
            clkSync_q <= 2'h0;
            hbSync_q  <= 2'h0;
            dSync1_q  <= 8'h00;
            dSync2_q  <= 8'h00;
        end else begin
            csSync_q  <= {csSync_q[0], chipSelect_n};
            wrSync_q  <= {wrSync_q[0], writeStrobe_n};
            rdSync_q  <= {rdSync_q[0], readStrobe_n};
            clkSync_q <= {clkSync_q[0], convClk};
            hbSync_q  <= {hbSync_q[0], highByteSelect};
            dSync1_q  <= dataIn;
            dSync2_q  <= dSync1_q;
        end
    end

    logic csN;
    logic wrN;
    logic rdN;
    logic clkS;
    assign csN  = csSync_q[1];
    // deselected: strobes and clock pin read as idle
    assign wrN  = csN | wrSync_q[1];
    assign rdN  = csN | rdSync_q[1];
    assign clkS = ~csN & clkSync_q[1];

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic wrPrev_q;
    logic rdPrev_q;
    logic clkPrev_q;
    logic wrRise;
    logic rdFall;
    logic clkRise;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPrev_q  <= 1'b1;
            rdPrev_q  <= 1'b1;
            clkPrev_q <= 1'b0;
        end else begin
            wrPrev_q  <= wrN;
            rdPrev_q  <= rdN;
            clkPrev_q <= clkS;
        end
    end

    assign wrRise  = wrN & ~wrPrev_q;
    assign rdFall  = ~rdN & rdPrev_q;
    assign clkRise = clkS & ~clkPrev_q;

    // ------------------------------------------------------------
    // control word
    // ------------------------------------------------------------
    logic [7:0] wordHold_q;
    logic [7:0] ctrl_q;
    logic       extClk_q;
    logic [1:0] pwrCode;

    // word is held while the strobe is low and taken on its rising edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wordHold_q <= adc_ctrl_pkg::CTRL_RESET;
        end else if (!wrN) begin
            wordHold_q <= dSync2_q;
        end
    end

    assign pwrCode = wordHold_q[adc_ctrl_pkg::PWR_HI_BIT:adc_ctrl_pkg::PWR_LO_BIT];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= adc_ctrl_pkg::CTRL_RESET;
            extClk_q <= adc_ctrl_pkg::EXT_CLK_RESET;
        end else if (wrRise) begin
            ctrl_q <= wordHold_q;
            case (pwrCode)
                adc_ctrl_pkg::PWR_INT_CLK: extClk_q <= 1'b0;
                adc_ctrl_pkg::PWR_EXT_CLK: extClk_q <= 1'b1;
                default:                   extClk_q <= extClk_q;
            endcase
        end
    end

    logic       acqExt;
    logic       singleEnded;
    logic       unipolar;
    logic [2:0] chan;
    assign acqExt      = ctrl_q[adc_ctrl_pkg::ACQ_BIT];
    assign singleEnded = ctrl_q[adc_ctrl_pkg::CFG_BIT];
    assign unipolar    = ctrl_q[adc_ctrl_pkg::POL_BIT];
    assign chan        = ctrl_q[adc_ctrl_pkg::CHAN_LSB +: 3];

    // ------------------------------------------------------------
    // input multiplexer
    // ------------------------------------------------------------
    function automatic logic [7:0] oneHot(input logic [2:0] idx);
        oneHot = 8'h01 << idx;
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            posInputSel     <= adc_ctrl_pkg::POS_SEL_RESET;
            negInputSel     <= adc_ctrl_pkg::NEG_SEL_RESET;
            sharedReturnSel <= 1'b0;
            bipolarRange    <= 1'b0;
        end else begin
            bipolarRange <= ~unipolar;
            if (singleEnded) begin
                posInputSel     <= oneHot(chan);
                negInputSel     <= 8'h00;
                sharedReturnSel <= 1'b1;
            end else begin
                posInputSel     <= oneHot(chan);
                negInputSel     <= oneHot(chan ^ 3'h1);
                sharedReturnSel <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // step timing: external pin edges or internal divider
    // ------------------------------------------------------------
    logic [adc_ctrl_pkg::STEP_W-1:0] divCnt_q;
    logic                            intTick;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= '0;
        end else if (intTick || wrRise) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_q + 1'b1;
        end
    end

    assign intTick = (divCnt_q == adc_ctrl_pkg::STEP_W'(adc_ctrl_pkg::INT_STEP_CYC - 1));

    logic step;
    // in internal mode the clock pin is ignored, so a tied pin is harmless
    assign step = extClk_q ? clkRise : intTick;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ACQ     = 3'b001,
        ST_ACQ_EXT = 3'b010,
        ST_CONV    = 3'b011,
        ST_SHUT    = 3'b100,
        ST_STANDBY = 3'b101
    } seq_e;

    seq_e                 state_q;
    logic [3:0]           stepCnt_q;
    logic [RES_W-1:0]     sar_q;
    logic [RES_W-1:0]     result_q;
    logic                 doneEvt;
    logic                 pendDown_q;
    logic [1:0]           pendCode_q;

    assign doneEvt = (state_q == ST_CONV) && step && (stepCnt_q == 4'h0);

    // a new word aborts any conversion in progress
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            stepCnt_q  <= 4'h0;
            sar_q      <= '0;
            result_q   <= '0;
            pendDown_q <= 1'b0;
            pendCode_q <= adc_ctrl_pkg::PWR_EXT_CLK;
        end else if (wrRise) begin
            pendCode_q <= pwrCode;
            pendDown_q <= ~pwrCode[1];
            sar_q      <= '0;
            if (state_q == ST_SHUT || state_q == ST_STANDBY) begin
                state_q <= ST_IDLE;
            end else if (wordHold_q[adc_ctrl_pkg::ACQ_BIT]) begin
                state_q <= ST_ACQ_EXT;
            end else if (state_q == ST_ACQ_EXT) begin
                state_q   <= ST_CONV;
                stepCnt_q <= 4'(adc_ctrl_pkg::CONV_CYCLES - 1);
            end else begin
                state_q   <= ST_ACQ;
                stepCnt_q <= 4'(adc_ctrl_pkg::ACQ_CYCLES - 1);
            end
        end else begin
            case (state_q)
                ST_ACQ: begin
                    if (step) begin
                        if (stepCnt_q == 4'h0) begin
                            state_q   <= ST_CONV;
                            stepCnt_q <= 4'(adc_ctrl_pkg::CONV_CYCLES - 1);
                        end else begin
                            stepCnt_q <= stepCnt_q - 4'h1;
                        end
                    end
                end
                ST_CONV: begin
                    if (step) begin
                        if (stepCnt_q == 4'h0) begin
                            // raw code is offset binary; bipolar flips the msb
                            result_q <= unipolar ? sar_q : (sar_q ^ {1'b1, {(RES_W-1){1'b0}}});
                            if (pendDown_q) begin
                                // power-down only after the conversion has finished
                                state_q <= (pendCode_q == adc_ctrl_pkg::PWR_STANDBY) ?
                                           ST_STANDBY : ST_SHUT;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else begin
                            if (stepCnt_q <= 4'(RES_W)) begin
                                sar_q[stepCnt_q - 4'h1] <= compOut;
                            end
                            stepCnt_q <= stepCnt_q - 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // trial code: decided bits plus current trial bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dacCode     <= '0;
            sampleHold  <= 1'b0;
            compIn      <= 1'b0;
            poweredDown <= 1'b0;
        end else begin
            // registered with the other activity flags so they never overlap
            poweredDown <= (state_q == ST_SHUT) || (state_q == ST_STANDBY);
            dacCode    <= (state_q == ST_CONV && stepCnt_q != 4'h0 && stepCnt_q <= 4'(RES_W)) ?
                          (sar_q | (RES_W'(1) << (stepCnt_q - 4'h1))) : sar_q;
            sampleHold <= (state_q == ST_CONV);
            compIn     <= (state_q == ST_ACQ) || (state_q == ST_ACQ_EXT);
        end
    end

    // ------------------------------------------------------------
    // completion flag
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            conversionDone_n <= 1'b1;
        end else if (doneEvt && !wrRise) begin
            conversionDone_n <= 1'b0;
        end else if (rdFall || wrRise) begin
            conversionDone_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // result read-back
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dataOut <= 8'h00;
        end else if (hbSync_q[1]) begin
            dataOut <= {{4{~unipolar & result_q[RES_W-1]}}, result_q[RES_W-1:8]};
        end else begin
            dataOut <= result_q[7:0];
        end
    end

    assign dataOe = ~rdN;
endmodule
`default_nettype wire

/* File: inc/adc_ctrl_pkg.sv */
// constants shared by the converter control logic
`default_nettype none
package adc_ctrl_pkg;
    // control word field positions
    localparam int unsigned PWR_HI_BIT   = 7;
    localparam int unsigned PWR_LO_BIT   = 6;
    localparam int unsigned ACQ_BIT      = 5;
    localparam int unsigned CFG_BIT      = 4;
    localparam int unsigned POL_BIT      = 3;
    localparam int unsigned CHAN_LSB     = 0;
    // power-select codes
    localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
    localparam logic [1:0] PWR_STANDBY   = 2'h1;
    localparam logic [1:0] PWR_INT_CLK   = 2'h2;
    localparam logic [1:0] PWR_EXT_CLK   = 2'h3;
    // reset values
    localparam logic [7:0] CTRL_RESET    = 8'hC8;
    localparam logic       EXT_CLK_RESET = 1'b1;
    // input selects that match the reset word: channel 0 against channel 1
    localparam logic [7:0] POS_SEL_RESET = 8'h01;
    localparam logic [7:0] NEG_SEL_RESET = 8'h02;
    // step counts
    localparam int unsigned ACQ_CYCLES   = 3;
    localparam int unsigned CONV_CYCLES  = 13;
    // timing at mclk 250 MHz
    localparam int unsigned MCLK_MHZ     = 250;
    localparam int unsigned INT_CONV_NS  = 3600;
    localparam int unsigned INT_ACQ_NS   = 1000;
    // internal clock step period: conversion time spread over 13 steps, rounded down
    localparam int unsigned INT_STEP_CYC = (INT_CONV_NS * MCLK_MHZ) / (1000 * CONV_CYCLES);
    localparam int unsigned INT_ACQ_CYC  = (INT_ACQ_NS * MCLK_MHZ) / 1000;
    localparam int unsigned STEP_W       = 10;
endpackage
`default_nettype wire

/* File: dv/adc_ctrl_properties.sv */
// port assertions for the converter control block
`default_nettype none
module adc_ctrl_properties (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        chipSelect_n,
    input wire logic        readStrobe_n,
    input wire logic        highByteSelect,
    input wire logic [7:0]  dataOut,
    input wire logic        dataOe,
    input wire logic        conversionDone_n,
    input wire logic        compIn,
    input wire logic [7:0]  posInputSel,
    input wire logic [7:0]  negInputSel,
    input wire logic        sharedReturnSel,
    input wire logic        bipolarRange,
    input wire logic        sampleHold,
    input wire logic        poweredDown
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_deselect_bus_off: assert property (chipSelect_n [*3] |-> !dataOe)
        else $error("bus driven while deselected");
    a_read_drives_bus: assert property ((!chipSelect_n && !readStrobe_n) [*3] |-> dataOe)
        else $error("bus not driven on read");
    a_done_read_clear: assert property ($rose(dataOe) |=> conversionDone_n)
        else $error("done flag not cleared by read");
    a_high_zero_fill: assert property ((dataOe && highByteSelect && !bipolarRange) [*4]
        |-> dataOut[7:4] == 4'h0) else $error("unipolar high byte fill wrong");
    a_high_sign_fill: assert property ((dataOe && highByteSelect && bipolarRange) [*4]
        |-> dataOut[7:4] == {4{dataOut[3]}}) else $error("bipolar high byte fill wrong");
    a_pos_onehot: assert property ($onehot(posInputSel))
        else $error("positive select not one-hot");
    a_neg_exclusive: assert property ($onehot({negInputSel, sharedReturnSel}))
        else $error("negative select not one-hot");
    a_pair_partner: assert property (!sharedReturnSel |-> negInputSel == {posInputSel[6],
        posInputSel[7], posInputSel[4], posInputSel[5], posInputSel[2], posInputSel[3],
        posInputSel[0], posInputSel[1]}) else $error("pair partner wrong");
    a_track_hold: assert property (!(compIn && sampleHold))
        else $error("track and hold together");
    a_powerdown_idle: assert property (poweredDown |-> !sampleHold && !compIn)
        else $error("activity while powered down");
    c_done: cover property ($fell(conversionDone_n));
    c_sleep: cover property ($rose(poweredDown));
    c_sign_read: cover property (dataOe && highByteSelect && bipolarRange);
endmodule
bind adc_parallel_control_interface adc_ctrl_properties i_adc_ctrl_properties (
    .mclk(mclk), .rst_n(rst_n), .chipSelect_n(chipSelect_n), .readStrobe_n(readStrobe_n),
    .highByteSelect(highByteSelect), .dataOut(dataOut), .dataOe(dataOe),
    .conversionDone_n(conversionDone_n), .compIn(compIn), .posInputSel(posInputSel),
    .negInputSel(negInputSel), .sharedReturnSel(sharedReturnSel),
    .bipolarRange(bipolarRange), .sampleHold(sampleHold), .poweredDown(poweredDown));
`default_nettype wire

/* File: dv/adc_host_model.sv */
// microprocessor model driving the parallel pins and conversion clock
`default_nettype none
module adc_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] dataOut,
    input  wire logic       dataOe,
    output logic            chipSelect_n,
    output logic            writeStrobe_n,
    output logic            readStrobe_n,
    output logic            highByteSelect,
    output logic            convClk,
    output logic [7:0]      dataIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] hostData;
    logic       hostEn;
    // a released bus shows the device data while it drives, else the inverse of the last value, never a stale copy
    assign dataIn = hostEn ? hostData : (dataOe ? dataOut : ~hostData);
    initial begin
        {chipSelect_n, writeStrobe_n, readStrobe_n} = 3'h7;
        highByteSelect = 1'b0;
        convClk = 1'b0;
        hostData = 8'h00;
        hostEn = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic write(input logic [7:0] w);
        tick(1);
        {chipSelect_n, writeStrobe_n, hostEn, hostData} = {3'h1, w};
        tick(4);
        writeStrobe_n = 1'b1;
        tick(1);
        chipSelect_n = 1'b1;
        hostEn = 1'b0;
    endtask
    // strobes with chip select high must leave the device untouched
    task automatic stray(input logic [7:0] w);
        {writeStrobe_n, readStrobe_n, convClk, hostEn, hostData} = {4'h3, w};
        tick(6);
        {writeStrobe_n, readStrobe_n, convClk} = 3'h6;
        tick(2);
        hostEn = 1'b0;
    endtask
    // 60 mclk period keeps the step clock inside the allowed band, 50% duty
    task automatic clocks(input int n);
        tick(1);
        chipSelect_n = 1'b0;
        repeat (n) begin
            tick(30);
            convClk = 1'b1;
            tick(30);
            convClk = 1'b0;
        end
        chipSelect_n = 1'b1;
    endtask
    task automatic read(output logic [7:0] lo, output logic [7:0] hi);
        tick(1);
        {chipSelect_n, readStrobe_n, highByteSelect} = 3'h0;
        tick(5);
        lo = dataIn;
        highByteSelect = 1'b1;
        tick(5);
        hi = dataIn;
        {chipSelect_n, readStrobe_n, highByteSelect} = 3'h6;
    endtask
endmodule
`default_nettype wire

/* File: dv/adc_parallel_control_interface_tb.sv */
// self-checking bench for the converter control block
`default_nettype none
module adc_parallel_control_interface_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RESET_WAIT = 2500; // 10 us at 4 ns
    localparam int WAKE_WAIT  = 12500; // 50 us settling with an external reference
    logic mclk, rst_n, compOut, poweredDown, sampleHold, compIn;
    logic cs_n, wr_n, rd_n, hbs, convClk, dataOe, conversionDone_n, sharedReturnSel;
    logic bipolarRange;
    logic [7:0] dataIn, dataOut, posInputSel, negInputSel;
    logic [11:0] dacCode, level = 12'h000;
    int seed = 32'h8005, miscompares = 0, testsRun = 0;
    always #2 mclk = ~mclk;
    // comparator model: high keeps the trial bit
    always @(posedge mclk) compOut <= #1 (dacCode <= level);
    adc_host_model i_adc_host_model (.mclk(mclk), .dataOut(dataOut), .dataOe(dataOe),
        .chipSelect_n(cs_n), .writeStrobe_n(wr_n), .readStrobe_n(rd_n),
        .highByteSelect(hbs), .convClk(convClk), .dataIn(dataIn));
    adc_parallel_control_interface i_adc_parallel_control_interface (.mclk(mclk),
        .rst_n(rst_n), .chipSelect_n(cs_n), .writeStrobe_n(wr_n), .readStrobe_n(rd_n),
        .highByteSelect(hbs), .convClk(convClk), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .conversionDone_n(conversionDone_n), .compIn(compIn),
        .compOut(compOut), .posInputSel(posInputSel), .negInputSel(negInputSel),
        .sharedReturnSel(sharedReturnSel), .bipolarRange(bipolarRange), .dacCode(dacCode),
        .sampleHold(sampleHold), .poweredDown(poweredDown));
    // ----------------------------------------
    // model and tasks
    // ----------------------------------------
    function automatic logic [16:0] selExp(input logic [7:0] w);
        logic [7:0] p;
        p = 8'h01 << w[2:0];
        if (w[4]) return {p, 8'h00, 1'b1};
        return {p, (w[0] ? p >> 1 : p << 1), 1'b0};
    endfunction
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic convert(input logic [7:0] w, input bit ext);
        logic [7:0] lo, hi;
        logic [11:0] r;
        int n;
        level = 12'($random(seed));
        i_adc_host_model.write(w);
        // external acquisition: a second word with the acquisition bit clear starts conversion
        if (w[5]) i_adc_host_model.write(w & 8'hDF);
        if (ext) begin
            i_adc_host_model.clocks(w[5] ? 13 : 16);
            check(conversionDone_n, 1'b0);
        end
        for (n = 0; n < 2000 && conversionDone_n !== 1'b0; n++) i_adc_host_model.tick(1);
        check(conversionDone_n, 1'b0);
        r = w[3] ? level : level ^ 12'h800;
        check({posInputSel, negInputSel, sharedReturnSel}, selExp(w));
        check(bipolarRange, !w[3]);
        i_adc_host_model.read(lo, hi);
        check(lo, r[7:0]);
        check(hi, {(w[3] ? 4'h0 : {4{r[11]}}), r[11:8]});
        check(conversionDone_n, 1'b1);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        summarize();
    end
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        repeat (12) @(posedge mclk);
        #1 rst_n = 1'b1;
        i_adc_host_model.tick(1);
        check({conversionDone_n, dataOe}, 2'h2);
        check({posInputSel, negInputSel, sharedReturnSel}, selExp(8'hC8));
        i_adc_host_model.tick(RESET_WAIT);
        for (int i = 0; i < 8; i++) begin
            convert({3'h6, i[1], ~i[0], i[2:0]}, 1'b1);
        end
        convert(8'hF2, 1'b1);
        convert(8'hB9, 1'b0);
        convert(8'h94, 1'b0);
        convert(8'h0B, 1'b0);
        check(poweredDown, 1'b1);
        i_adc_host_model.write(8'h9B);
        i_adc_host_model.tick(5);
        check(poweredDown, 1'b0);
        i_adc_host_model.tick(WAKE_WAIT);
        convert(8'hD5, 1'b1);
        convert(8'h55, 1'b1);
        check(poweredDown, 1'b1);
        i_adc_host_model.write(8'hD5);
        i_adc_host_model.tick(5);
        check(poweredDown, 1'b0);
        i_adc_host_model.stray(8'h12);
        i_adc_host_model.tick(5);
        check({posInputSel, negInputSel, sharedReturnSel}, selExp(8'hD5));
        check(conversionDone_n, 1'b1);
        // reset during acquisition while internal clock mode is selected
        i_adc_host_model.write(8'h9B);
        i_adc_host_model.tick(20);
        rst_n = 1'b0;
        i_adc_host_model.tick(3);
        rst_n = 1'b1;
        i_adc_host_model.tick(1);
        check({conversionDone_n, dataOe, poweredDown}, 3'h4);
        check({posInputSel, negInputSel, sharedReturnSel}, selExp(8'hC8));
        i_adc_host_model.tick(RESET_WAIT);
        // a power-down word keeps the clock mode, which reset has set back to external
        convert(8'h0B, 1'b1);
        check(poweredDown, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
